// [src/sacu_pkg.sv]
// Constants shared by the function-command unit and its timing table
package sacu_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int CMD_TAIL_NS = 1090;
	localparam int CMD_TAIL_CYC = CMD_TAIL_NS / CLK_PERIOD_NS;
	localparam int PROG_FULL_MULT = 8;
	localparam int BUSY_CNT_W = 24;

	// ------------------------------------------------------------
	// Command codes and read pointer targets
	// ------------------------------------------------------------
	localparam int CMD_COUNT = 14;
	localparam logic [7:0] CMD_COPY = 8'h5A;
	localparam logic [7:0] CMD_MASTER_RESET = 8'hF0;
	localparam logic [7:0] CMD_RESET_PULSE = 8'hB4;
	localparam logic [7:0] PTR_MASTER_STATUS = 8'h00;
	localparam logic [7:0] PTR_DATA = 8'h01;
	localparam logic [7:0] CMD_TABLE [CMD_COUNT] = '{
		CMD_COPY, CMD_MASTER_RESET, CMD_RESET_PULSE, 8'h87, 8'h96,
		8'hA5, 8'hC3, 8'hD2, 8'hE1, 8'h0F, 8'h1E, 8'h2D, 8'h3C, 8'h4B};
	localparam logic [7:0] PTR_TABLE [CMD_COUNT] = '{
		PTR_MASTER_STATUS, PTR_MASTER_STATUS, PTR_MASTER_STATUS,
		PTR_MASTER_STATUS, PTR_DATA, PTR_DATA, PTR_DATA, PTR_DATA,
		PTR_MASTER_STATUS, PTR_MASTER_STATUS, PTR_DATA, PTR_DATA,
		PTR_MASTER_STATUS, PTR_DATA};

	// ------------------------------------------------------------
	// Copy parameter byte fields
	// ------------------------------------------------------------
	localparam int PB_DEST_BIT = 7;
	localparam int PB_TT_HI = 5;
	localparam int PB_TT_LO = 4;
	localparam int PB_FS_BIT = 3;
	localparam int PB_SEG_HI = 2;
	localparam int PAGE_BYTES = 32;
	localparam int SEG_BYTES = 4;
	localparam int PAGE_COUNT = 2;

	// ------------------------------------------------------------
	// Port timing code conversion
	// ------------------------------------------------------------
	localparam logic [9:0] RSTL_NORMAL_BASE_US = 10'h1B8;
	localparam logic [9:0] RSTL_NORMAL_STEP_US = 10'h014;
	localparam logic [9:0] RSTL_FAST_BASE_US = 10'h02C;
	localparam logic [9:0] RSTL_FAST_STEP_US = 10'h002;
	localparam logic [3:0] REC_FLAT_CODE = 4'h5;
	localparam logic [7:0] REC_STEP_TENTH_US = 8'h19;
	localparam logic [7:0] REC_MAX_TENTH_US = 8'hFA;
	localparam logic [3:0] PULLUP_SWITCH_CODE = 4'h6;
	localparam logic [9:0] PULLUP_LOW_OHM = 10'h1F4;
	localparam logic [9:0] PULLUP_HIGH_OHM = 10'h3E8;

	typedef enum logic [1:0] {
		SACU_IDLE = 2'b00,
		SACU_PARAM = 2'b01,
		SACU_BUSY = 2'b10,
		SACU_DONE = 2'b11
	} sacu_state_e;
endpackage

// [src/sacu_timing_if.sv]
// Carrier between the command unit and its timing code table
`timescale 1ns/10ps
`default_nettype none
interface sacu_timing_if;
	logic [3:0] reset_code;
	logic [3:0] recovery_code;
	logic [3:0] pullup_code;
	logic fast_speed;
	logic [9:0] bus_reset_low_time;
	logic [7:0] recovery_time;
	logic [9:0] weak_pullup_resistance;
	modport table_side (input reset_code, recovery_code, pullup_code,
		fast_speed, output bus_reset_low_time, recovery_time,
		weak_pullup_resistance);
	modport user_side (output reset_code, recovery_code, pullup_code,
		fast_speed, input bus_reset_low_time, recovery_time,
		weak_pullup_resistance);
endinterface
`default_nettype wire

// [src/sacu_timing_lut.sv]
// Conversion of four-bit port timing codes to values
`timescale 1ns/10ps
`default_nettype none
module sacu_timing_lut (
	sacu_timing_if.table_side tim
);
	wire [9:0] code_rst;
	wire [7:0] code_rec;
	wire [9:0] normal_rst;
	wire [9:0] fast_rst;
	wire [7:0] rec_steps;

	assign code_rst = {6'h00, tim.reset_code};
	assign code_rec = {4'h0, tim.recovery_code};
	// Reset low time, one line per speed
	assign normal_rst = 10'(sacu_pkg::RSTL_NORMAL_BASE_US
		+ code_rst * sacu_pkg::RSTL_NORMAL_STEP_US);
	assign fast_rst = 10'(sacu_pkg::RSTL_FAST_BASE_US
		+ code_rst * sacu_pkg::RSTL_FAST_STEP_US);
	assign tim.bus_reset_low_time = tim.fast_speed ? fast_rst : normal_rst;
	// Recovery in tenths of a microsecond, flat then stepping, then capped
	assign rec_steps = (tim.recovery_code <= sacu_pkg::REC_FLAT_CODE) ?
		8'h01 : 8'(code_rec - 8'h04);
	assign tim.recovery_time =
		(tim.recovery_code == 4'hF) ? sacu_pkg::REC_MAX_TENTH_US :
		8'(rec_steps * sacu_pkg::REC_STEP_TENTH_US);
	assign tim.weak_pullup_resistance =
		(tim.pullup_code < sacu_pkg::PULLUP_SWITCH_CODE) ?
		sacu_pkg::PULLUP_LOW_OHM : sacu_pkg::PULLUP_HIGH_OHM;
endmodule
`default_nettype wire

// [src/sacu_top.sv]
// Function-command interpreter with scratch buffer to user page copy
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module sacu_top #(
	parameter int PROG_TIME_US = 10000
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	output logic rx_ack,
	output logic busy,
	output logic cmd_done,
	output logic cmd_strobe,
	output logic [7:0] cmd_code,
	output logic [7:0] read_ptr,
	input wire logic scratch_wr_en,
	input wire logic [4:0] scratch_wr_addr,
	input wire logic [7:0] scratch_wr_data,
	input wire logic [5:0] eeprom_rd_addr,
	output logic [7:0] eeprom_rd_data,
	input wire logic [1:0] page_lock,
	input wire logic [15:0] segment_lock,
	input wire logic [7:0] reset_code,
	input wire logic [3:0] recovery_code,
	input wire logic [3:0] pullup_code,
	input wire logic fast_speed,
	output logic [9:0] bus_reset_low_time,
	output logic [7:0] recovery_time,
	output logic [9:0] weak_pullup_resistance
);
	localparam int PROG_CYC = PROG_TIME_US * 1000 / sacu_pkg::CLK_PERIOD_NS;
	localparam int TAIL_BOUND = sacu_pkg::CMD_TAIL_CYC;
	localparam int EE_BYTES = sacu_pkg::PAGE_BYTES * sacu_pkg::PAGE_COUNT;

	sacu_pkg::sacu_state_e state;
	sacu_pkg::sacu_state_e next_state;
	logic [7:0] scratch_buffer [sacu_pkg::PAGE_BYTES];
	logic [7:0] eeprom [EE_BYTES];
	logic [sacu_pkg::BUSY_CNT_W-1:0] busy_cnt;
	logic cp_user;
	logic cp_page;
	logic cp_fs;
	logic [2:0] cp_seg;
	logic [7:0] next_ptr;
	logic [sacu_pkg::CMD_COUNT-1:0] cmd_hit;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	genvar g;
	for (g = 0; g < sacu_pkg::CMD_COUNT; g++) begin : g_cmd
		assign cmd_hit[g] = rx_byte == sacu_pkg::CMD_TABLE[g];
	end

	always_comb begin
		next_ptr = 8'h00;
		for (int k = 0; k < sacu_pkg::CMD_COUNT; k++) begin
			if (cmd_hit[k]) begin
				next_ptr = sacu_pkg::PTR_TABLE[k];
			end
		end
	end

	wire cmd_known = |cmd_hit;
	wire in_idle = state == sacu_pkg::SACU_IDLE;
	wire in_param = state == sacu_pkg::SACU_PARAM;
	wire cmd_take = rx_valid && in_idle && cmd_known;
	wire is_copy = rx_byte == sacu_pkg::CMD_COPY;

	// ------------------------------------------------------------
	// Copy parameter decode
	// ------------------------------------------------------------
	wire dest_user = rx_byte[sacu_pkg::PB_DEST_BIT];
	wire [1:0] target_page_field =
		rx_byte[sacu_pkg::PB_TT_HI:sacu_pkg::PB_TT_LO];
	wire fs_req = rx_byte[sacu_pkg::PB_FS_BIT];
	wire [2:0] segment_index = rx_byte[sacu_pkg::PB_SEG_HI:0];
	wire tgt_page = target_page_field[0];
	// Page field 1x is reserved for a user target, 00 only otherwise
	wire param_ok = dest_user ? !target_page_field[1] :
		(target_page_field == 2'b00);
	wire [7:0] page_seg_lock = tgt_page ? segment_lock[15:8] :
		segment_lock[7:0];
	wire eff_fs = fs_req || (|page_seg_lock);
	wire tgt_locked = dest_user && (page_lock[tgt_page]
		|| (eff_fs && page_seg_lock[segment_index]));
	wire param_take = rx_valid && in_param && param_ok;
	// A secret-area target has no user page and always takes full time
	wire [sacu_pkg::BUSY_CNT_W-1:0] busy_len = (dest_user && eff_fs) ?
		sacu_pkg::BUSY_CNT_W'(PROG_CYC) :
		sacu_pkg::BUSY_CNT_W'(PROG_CYC * sacu_pkg::PROG_FULL_MULT);
	wire commit = (state == sacu_pkg::SACU_BUSY) &&
		(busy_cnt == sacu_pkg::BUSY_CNT_W'(1));

	// Busy bytes and bad bytes alike get no acknowledge
	assign rx_ack = cmd_take || param_take;
	assign busy = state == sacu_pkg::SACU_BUSY;
	assign cmd_done = state == sacu_pkg::SACU_DONE;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			sacu_pkg::SACU_IDLE: begin
				if (cmd_take && is_copy) begin
					next_state = sacu_pkg::SACU_PARAM;
				end
			end
			sacu_pkg::SACU_PARAM: begin
				if (param_take) begin
					next_state = tgt_locked ? sacu_pkg::SACU_DONE :
						sacu_pkg::SACU_BUSY;
				end else if (rx_valid) begin
					next_state = sacu_pkg::SACU_IDLE;
				end
			end
			sacu_pkg::SACU_BUSY: begin
				if (commit) begin
					next_state = sacu_pkg::SACU_DONE;
				end
			end
			default: begin
				next_state = sacu_pkg::SACU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= sacu_pkg::SACU_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			busy_cnt <= '0;
		end else if (param_take) begin
			busy_cnt <= busy_len;
		end else if (busy) begin
			busy_cnt <= busy_cnt - sacu_pkg::BUSY_CNT_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cp_user <= 1'b0;
			cp_page <= 1'b0;
			cp_fs <= 1'b0;
			cp_seg <= 3'h0;
		end else if (param_take) begin
			cp_user <= dest_user;
			cp_page <= tgt_page;
			cp_fs <= eff_fs;
			cp_seg <= segment_index;
		end
	end

	// Copy takes no other setting; only the pointer and cmd_code are touched
	always_ff @(posedge clock) begin
		if (reset) begin
			read_ptr <= sacu_pkg::PTR_MASTER_STATUS;
			cmd_strobe <= 1'b0;
			cmd_code <= 8'h00;
		end else begin
			// Copy never reaches the single-wire side
			cmd_strobe <= cmd_take && !is_copy;
			if (cmd_take) begin
				read_ptr <= next_ptr;
				cmd_code <= rx_byte;
			end
		end
	end

	// ------------------------------------------------------------
	// Scratch buffer and user pages
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (scratch_wr_en) begin
			scratch_buffer[scratch_wr_addr] <= scratch_wr_data;
		end
	end

	// One writer per byte; a segment maps to the same scratch offset
	for (g = 0; g < EE_BYTES; g++) begin : g_ee
		localparam logic PG = 1'(g / sacu_pkg::PAGE_BYTES);
		localparam int OFS = g % sacu_pkg::PAGE_BYTES;
		localparam logic [2:0] SG = 3'(OFS / sacu_pkg::SEG_BYTES);
		wire wr_hit = commit && cp_user && (cp_page == PG)
			&& (!cp_fs || cp_seg == SG);
		always_ff @(posedge clock) begin
			if (wr_hit) begin
				eeprom[g] <= scratch_buffer[OFS];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			eeprom_rd_data <= 8'h00;
		end else begin
			eeprom_rd_data <= eeprom[eeprom_rd_addr];
		end
	end

	// ------------------------------------------------------------
	// Timing code table
	// ------------------------------------------------------------
	sacu_timing_if tim ();
	assign tim.reset_code = fast_speed ? reset_code[7:4] : reset_code[3:0];
	assign tim.recovery_code = recovery_code;
	assign tim.pullup_code = pullup_code;
	assign tim.fast_speed = fast_speed;
	sacu_timing_lut u_lut (.tim(tim.table_side));

	always_ff @(posedge clock) begin
		if (reset) begin
			bus_reset_low_time <= 10'h000;
			recovery_time <= 8'h00;
			weak_pullup_resistance <= 10'h000;
		end else begin
			bus_reset_low_time <= tim.bus_reset_low_time;
			recovery_time <= tim.recovery_time;
			weak_pullup_resistance <= tim.weak_pullup_resistance;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [sacu_pkg::BUSY_CNT_W-1:0] busy_run;
	logic [sacu_pkg::BUSY_CNT_W-1:0] busy_exp;
	always_ff @(posedge clock) begin
		if (reset || param_take) begin
			busy_run <= '0;
			busy_exp <= busy_len;
		end else if (busy) begin
			busy_run <= busy_run + sacu_pkg::BUSY_CNT_W'(1);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	property p_nack_unknown;
		rx_valid && in_idle && !cmd_known |-> !rx_ack;
	endproperty
	a_nack_unknown: assert property (p_nack_unknown)
		else $error("unknown command acknowledged");

	property p_nack_reserved;
		rx_valid && in_param && rx_byte[7] && rx_byte[5] |-> !rx_ack;
	endproperty
	a_nack_reserved: assert property (p_nack_reserved)
		else $error("reserved page code acknowledged");

	property p_busy_len;
		$fell(busy) |-> busy_run == busy_exp;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy time differs from program time multiple");

	property p_tail;
		$fell(busy) |-> ##[0:TAIL_BOUND] cmd_done;
	endproperty
	a_tail: assert property (p_tail)
		else $error("copy not finished in tail time");

	property p_locked_idle;
		param_take && tgt_locked |=> !busy ##1 in_idle && !busy;
	endproperty
	a_locked_idle: assert property (p_locked_idle)
		else $error("protected copy went busy");

	property p_ptr_status;
		cmd_take && is_copy |=> read_ptr == sacu_pkg::PTR_MASTER_STATUS;
	endproperty
	a_ptr_status: assert property (p_ptr_status)
		else $error("copy left pointer off status");

	property p_no_strobe;
		!in_idle |-> ##1 !cmd_strobe;
	endproperty
	a_no_strobe: assert property (p_no_strobe)
		else $error("command strobe during copy");

	property p_copy_seg;
		commit && cp_user && cp_fs |=> eeprom[{cp_page, cp_seg, 2'b00}]
			== scratch_buffer[{cp_seg, 2'b00}];
	endproperty
	a_copy_seg: assert property (p_copy_seg)
		else $error("segment byte not copied from its scratch slot");

	property p_pullup;
		pullup_code >= sacu_pkg::PULLUP_SWITCH_CODE
			|=> weak_pullup_resistance == sacu_pkg::PULLUP_HIGH_OHM;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pullup value wrong for code");

	property p_ptr_cmd;
		cmd_take |=> read_ptr == $past(next_ptr);
	endproperty
	a_ptr_cmd: assert property (p_ptr_cmd)
		else $error("pointer not moved by command");
endmodule
`default_nettype wire

// [dv/sacu_host_model.sv]
// Host-side model: sends command bytes and fills the scratch buffer
`timescale 1ns/10ps
`default_nettype none
module sacu_host_model (
	input wire logic clock,
	input wire logic rx_ack,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic scratch_wr_en,
	output logic [4:0] scratch_wr_addr,
	output logic [7:0] scratch_wr_data
);
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		scratch_wr_en = 1'b0;
		scratch_wr_addr = 5'h00;
		scratch_wr_data = 8'h00;
	end
	// One byte per call; ack is read while the byte still stands
	task automatic send_byte(input logic [7:0] b, output logic ack);
		@(posedge clock);
		#1;
		rx_valid = 1'b1;
		rx_byte = b;
		@(negedge clock);
		ack = rx_ack;
		@(posedge clock);
		#1;
		rx_valid = 1'b0;
		// Released lines show the inverse so a stale byte never matches
		rx_byte = ~b;
	endtask
	// Scratch buffer gets base+i before a copy is issued
	task automatic load_scratch(input logic [7:0] base);
		for (int i = 0; i < 32; i++) begin
			@(posedge clock);
			#1;
			scratch_wr_en = 1'b1;
			scratch_wr_addr = 5'(i);
			scratch_wr_data = base + 8'(i);
		end
		@(posedge clock);
		#1;
		scratch_wr_en = 1'b0;
	endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the function-command unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int PROG_CYC = 10;
	localparam int FULL_CYC = PROG_CYC * sacu_pkg::PROG_FULL_MULT;
	logic clock, reset, rx_valid, rx_ack, busy, cmd_done, cmd_strobe;
	logic [7:0] rx_byte, cmd_code, read_ptr, eeprom_rd_data, recovery_time;
	logic scratch_wr_en, fast_speed;
	logic [4:0] scratch_wr_addr;
	logic [7:0] scratch_wr_data, reset_code;
	logic [5:0] eeprom_rd_addr;
	logic [1:0] page_lock;
	logic [15:0] segment_lock;
	logic [3:0] recovery_code, pullup_code;
	logic [9:0] bus_reset_low_time, weak_pullup_resistance;
	logic [7:0] bad [4] = '{8'hA0, 8'hB8, 8'h10, 8'h20};
	int fails = 0;
	int comparisons = 0;

	sacu_top #(.PROG_TIME_US(1)) u_sacu_top (.clock(clock), .reset(reset),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ack(rx_ack),
		.busy(busy), .cmd_done(cmd_done), .cmd_strobe(cmd_strobe),
		.cmd_code(cmd_code), .read_ptr(read_ptr),
		.scratch_wr_en(scratch_wr_en), .scratch_wr_addr(scratch_wr_addr),
		.scratch_wr_data(scratch_wr_data), .eeprom_rd_addr(eeprom_rd_addr),
		.eeprom_rd_data(eeprom_rd_data), .page_lock(page_lock),
		.segment_lock(segment_lock), .reset_code(reset_code),
		.recovery_code(recovery_code), .pullup_code(pullup_code),
		.fast_speed(fast_speed), .bus_reset_low_time(bus_reset_low_time),
		.recovery_time(recovery_time),
		.weak_pullup_resistance(weak_pullup_resistance));
	sacu_host_model u_sacu_host_model (.clock(clock), .rx_ack(rx_ack),
		.rx_valid(rx_valid), .rx_byte(rx_byte),
		.scratch_wr_en(scratch_wr_en), .scratch_wr_addr(scratch_wr_addr),
		.scratch_wr_data(scratch_wr_data));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Run needs about 800 cycles; the limit of 10000 cycles leaves a wide margin
	initial begin
		#1000000;
		fails++;
		finish_test();
	end

	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic send(input logic [7:0] b, input logic exp,
		input string nm);
		logic a;
		u_sacu_host_model.send_byte(b, a);
		check(nm, 16'(a), 16'(exp));
	endtask
	task automatic ee_rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clock);
		#1;
		eeprom_rd_addr = a;
		@(posedge clock);
		#1;
		check("eeprom", 16'(eeprom_rd_data), 16'(exp));
	endtask
	// Counts busy cycles, then expects the single done cycle
	task automatic wait_copy(input int n);
		int k;
		k = 0;
		while (busy === 1'b1 && k < 200) begin
			@(posedge clock);
			#1;
			k++;
		end
		check("busy_cycles", 16'(k), 16'(n));
		check("cmd_done", 16'(cmd_done), 16'h0001);
		check("cmd_strobe", 16'(cmd_strobe), 16'h0000);
		check("read_ptr", 16'(read_ptr), 16'(sacu_pkg::PTR_MASTER_STATUS));
	endtask
	task automatic copy(input logic [7:0] p, input int n);
		send(sacu_pkg::CMD_COPY, 1'b1, "ack_code");
		send(p, 1'b1, "ack_param");
		wait_copy(n);
	endtask

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		eeprom_rd_addr = 6'h00;
		page_lock = 2'h0;
		segment_lock = 16'h0000;
		reset_code = 8'h00;
		recovery_code = 4'h0;
		pullup_code = 4'h0;
		fast_speed = 1'b0;
		repeat (5) @(posedge clock);
		#1;
		reset = 1'b0;
		check("busy", 16'(busy), 16'h0000);
		check("read_ptr", 16'(read_ptr), 16'h0000);
		send(8'h00, 1'b0, "ack_unknown");
		send(8'hFF, 1'b0, "ack_unknown");
		for (int i = 1; i < sacu_pkg::CMD_COUNT; i++) begin
			send(sacu_pkg::CMD_TABLE[i], 1'b1, "ack_cmd");
			check("cmd_strobe", 16'(cmd_strobe), 16'h0001);
			check("cmd_code", 16'(cmd_code), 16'(sacu_pkg::CMD_TABLE[i]));
			check("read_ptr", 16'(read_ptr), 16'(sacu_pkg::PTR_TABLE[i]));
		end
		u_sacu_host_model.load_scratch(8'h10);
		copy(8'h80, FULL_CYC);
		for (int i = 0; i < 32; i++)
			ee_rd({1'b0, 5'(i)}, 8'h10 + 8'(i));
		u_sacu_host_model.load_scratch(8'h30);
		// Bit 6 set on purpose: it must be ignored
		copy(8'hD0, FULL_CYC);
		for (int i = 0; i < 32; i++)
			ee_rd({1'b1, 5'(i)}, 8'h30 + 8'(i));
		u_sacu_host_model.load_scratch(8'hC0);
		for (int s = 0; s < 8; s++) begin
			copy(8'h98 | 8'(s), PROG_CYC);
			for (int k = 0; k < 4; k++)
				ee_rd({1'b1, 5'(4 * s + k)}, 8'hC0 + 8'(4 * s + k));
			if (s < 7)
				ee_rd({1'b1, 5'(4 * s + 4)}, 8'h30 + 8'(4 * s + 4));
		end
		send(sacu_pkg::CMD_COPY, 1'b1, "ack_code");
		send(8'h00, 1'b1, "ack_secret");
		send(sacu_pkg::CMD_MASTER_RESET, 1'b0, "ack_busy");
		wait_copy(FULL_CYC - 2);
		ee_rd(6'h00, 8'h10);
		foreach (bad[i]) begin
			send(sacu_pkg::CMD_COPY, 1'b1, "ack_code");
			send(bad[i], 1'b0, "ack_reserved");
		end
		// Page 1 segment 3 locked
		segment_lock = 16'h0800;
		u_sacu_host_model.load_scratch(8'h50);
		copy(8'h9B, 0);
		ee_rd(6'h2C, 8'hCC);
		copy(8'h90, PROG_CYC);
		ee_rd(6'h20, 8'h50);
		ee_rd(6'h24, 8'hC4);
		page_lock = 2'h1;
		copy(8'h80, 0);
		ee_rd(6'h00, 8'h10);
		for (int n = 0; n < 16; n++) begin
			@(posedge clock);
			#1;
			reset_code = {4'(15 - n), 4'(n)};
			recovery_code = 4'(n);
			pullup_code = 4'(n);
			fast_speed = n[0];
			@(posedge clock);
			#1;
			check("reset_low", 16'(bus_reset_low_time), fast_speed ?
				16'(44 + 2 * (15 - n)) : 16'(440 + 20 * n));
			check("recovery", 16'(recovery_time), n <= 5 ? 16'h0019 :
				(n >= 14 ? 16'h00FA : 16'(25 * (n - 4))));
			check("pullup", 16'(weak_pullup_resistance),
				n < 6 ? 16'h01F4 : 16'h03E8);
		end
		finish_test();
	end
endmodule
`default_nettype wire
